// file: inc/dfc_host_regs.vh
// Register map, field positions and constants of the FIFO host controller
`ifndef DFC_HOST_REGS_VH
`define DFC_HOST_REGS_VH

// Register word offsets (byte address = offset)
`define DFC_REG_CTRL     8'h00
`define DFC_REG_STATUS   8'h04
`define DFC_REG_IRQ_STS  8'h08
`define DFC_REG_IRQ_MSK  8'h0c
`define DFC_REG_WDATA    8'h10
`define DFC_REG_RDATA    8'h14
`define DFC_REG_BLOCK    8'h18
`define DFC_REG_LEVEL    8'h1c

// Control fields
`define DFC_CTRL_SYNC_MODE  0
`define DFC_CTRL_SI_LEVEL   1
`define DFC_CTRL_WR_GATE    2
`define DFC_CTRL_RESET      3

// Interrupt status fields
`define DFC_IRQ_NEAR      0
`define DFC_IRQ_HALF      1
`define DFC_IRQ_FULL      2
`define DFC_IRQ_EMPTY     3
`define DFC_IRQ_BLK_DONE  4
`define DFC_IRQ_W         5

// Command codes in the block register
`define DFC_CMD_NONE   2'h0
`define DFC_CMD_WRITE  2'h1
`define DFC_CMD_LOAD   2'h2
`define DFC_CMD_SHIFT  2'h3

// Timing
`define DFC_CLK_HZ         20000000
`define DFC_RESET_NS       50
`define DFC_RESET_CYC      ((`DFC_RESET_NS * (`DFC_CLK_HZ / 1000000) + 999) / 1000)
`define DFC_LATENCY_NS     20
`define DFC_LATENCY_CYC    ((`DFC_LATENCY_NS * (`DFC_CLK_HZ / 1000000) + 999) / 1000)

// Flag thresholds, in words
`define DFC_DEPTH        4096
`define DFC_HALF         2048
`define DFC_NEAR         8

`endif

// file: rtl/dfc_host.v
// Host controller that drives a dual-clock 9-bit FIFO through its pins
// Overview of operation
// - Common clock: enables and load/shift all change on one edge.
// - Common clock: full flag may gate one write enable directly.
// - Common clock: empty flag may gate the read enable directly.
// - Unrelated clocks: enables are generated here, never straight from flags.
// - Unrelated clocks: writes and reads synchronise at the full and empty boundaries.
// - Near and half flags act as early warnings before block transfers.
// - Chain serial input is extra control bits or a fixed level.
// - Later devices take serial input from a prior device output.
// - Chosen output pin sets one to nine bits added per device.
// - Chained write enables may be gated by full flags.
// - Read alignment in a chain needs logic outside the devices.
// - Word width need not be a multiple of nine.
// - Write stores data when both write enables high; no flag interlock.
// - Read enable with load high loads; low shifts, serial input into top bit.
`timescale 1ns/1ps
`include "dfc_host_regs.vh"

module dfc_host #(
   parameter DW = 9,
   parameter CW = 16
) (
   // Clock and reset
   input  wire          core_clk,
   input  wire          rstn,
   // Wishbone slave
   input  wire          wb_cyc_i,
   input  wire          wb_stb_i,
   input  wire          wb_we_i,
   input  wire [7:0]    wb_adr_i,
   input  wire [3:0]    wb_sel_i,
   input  wire [31:0]   wb_dat_i,
   output reg  [31:0]   wb_dat_o,
   output reg           wb_ack_o,
   // Interrupt
   output reg           irq_o,
   // FIFO device pins, both port clocks from core_clk
   output reg           write_port_clock_en,
   output reg           read_port_clock_en,
   output reg           async_reset_n,
   output reg           write_enable_a,
   output reg           write_enable_b,
   output reg  [DW-1:0] write_data_in,
   output reg           read_enable,
   output reg           load_not_shift,
   output reg           serial_in,
   input  wire [DW-1:0] read_data_out,
   input  wire          empty_flag_n,
   input  wire          near_boundary_flag_n,
   input  wire          half_full_flag_n,
   input  wire          full_flag_n
);

   localparam ST_IDLE  = 3'h0;
   localparam ST_RESET = 3'h1;
   localparam ST_WRITE = 3'h2;
   localparam ST_READ  = 3'h3;
   localparam ST_WAIT  = 3'h4;

   localparam integer RST_CYC_I = `DFC_RESET_CYC;
   localparam integer LAT_CYC_I = `DFC_LATENCY_CYC;
   localparam [7:0]   RST_CYC   = RST_CYC_I[7:0];
   localparam [7:0]   LAT_CYC   = LAT_CYC_I[7:0];

   reg  [3:0]           ctrl_q;
   reg  [`DFC_IRQ_W-1:0] ists_q;
   reg  [`DFC_IRQ_W-1:0] imsk_q;
   reg  [DW-1:0]        wdata_q;
   reg  [DW-1:0]        rdata_q;
   reg  [1:0]           cmd_q;
   reg  [CW-1:0]        count_q;
   reg  [2:0]           state_q;
   reg  [7:0]           tmr_q;
   reg  [3:0]           flags_q;
   reg                  busy_q;
   reg                  rd_pend_q;
   reg                  wr_pend_q;
   reg  [12:0]          lvl_lo_q;

   wire                 acc    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire                 wr_acc = acc & wb_we_i & wb_sel_i[0];
   wire                 blk_go = wr_acc & (wb_adr_i == `DFC_REG_BLOCK) & ~busy_q;
   wire                 rst_go = wr_acc & (wb_adr_i == `DFC_REG_CTRL)
                                 & wb_dat_i[`DFC_CTRL_RESET] & ~busy_q;
   wire                 sync_m = ctrl_q[`DFC_CTRL_SYNC_MODE];

   // Flag decode, active high
   // fill pattern decode
   wire f_empty = ~flags_q[0];
   wire f_full  = ~flags_q[3];

   // Level class shown to software: 0 empty .. 5 full
   reg  [2:0] lvl_class;
   always @* begin
      case (flags_q)
         4'b1100: lvl_class = 3'h0;
         4'b1101: lvl_class = 3'h1;
         4'b1111: lvl_class = 3'h2;
         4'b1011: lvl_class = 3'h3;
         4'b1001: lvl_class = 3'h4;
         4'b0001: lvl_class = 3'h5;
         default: lvl_class = 3'h7;
      endcase
   end

   // Previous flags, for edge events
   reg  [3:0] flags_p_q;
   wire [3:0] flag_rise = ~flags_q & flags_p_q;

   // Write gate from full flag in common-clock mode
   // full flag blocks overrun
   wire wr_ok = ~(sync_m & ctrl_q[`DFC_CTRL_WR_GATE] & f_full);
   wire rd_ok = ~(sync_m & f_empty);
   // Flags lag a pulse by two edges; pacing keeps each decision on fresh flags
   wire pace_ok = ~read_enable & ~rd_pend_q & ~write_enable_a & ~wr_pend_q;

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flags_q   <= 4'hc;
         flags_p_q <= 4'hc;
      end else begin
         flags_q   <= {full_flag_n, half_full_flag_n, near_boundary_flag_n, empty_flag_n};
         flags_p_q <= flags_q;
      end
   end

   // Register slave
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_q   <= 4'h4;
         imsk_q   <= {`DFC_IRQ_W{1'b0}};
         wdata_q  <= {DW{1'b0}};
      end else begin
         wb_ack_o <= acc;
         if (wr_acc) begin
            case (wb_adr_i)
               `DFC_REG_CTRL:    ctrl_q  <= {1'b0, wb_dat_i[2:0]};
               `DFC_REG_IRQ_MSK: imsk_q  <= wb_dat_i[`DFC_IRQ_W-1:0];
               `DFC_REG_WDATA:   wdata_q <= wb_dat_i[DW-1:0];
               default:          ;
            endcase
         end
         if (acc && !wb_we_i) begin
            case (wb_adr_i)
               `DFC_REG_CTRL:    wb_dat_o <= {28'h0, ctrl_q};
               `DFC_REG_STATUS:  wb_dat_o <= {24'h0, busy_q, lvl_class, flags_q};
               `DFC_REG_IRQ_STS: wb_dat_o <= {{(32-`DFC_IRQ_W){1'b0}}, ists_q};
               `DFC_REG_IRQ_MSK: wb_dat_o <= {{(32-`DFC_IRQ_W){1'b0}}, imsk_q};
               `DFC_REG_WDATA:   wb_dat_o <= {{(32-DW){1'b0}}, wdata_q};
               `DFC_REG_RDATA:   wb_dat_o <= {{(32-DW){1'b0}}, rdata_q};
               `DFC_REG_BLOCK:   wb_dat_o <= {{(30-CW){1'b0}}, count_q, cmd_q};
               `DFC_REG_LEVEL:   wb_dat_o <= {19'h0, lvl_lo_q};
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Sticky interrupt status; set wins over write-one clear
   // flag-edge and block-done interrupt events
   wire [`DFC_IRQ_W-1:0] ev;
   assign ev[`DFC_IRQ_NEAR]     = flag_rise[1];
   assign ev[`DFC_IRQ_HALF]     = flag_rise[2];
   assign ev[`DFC_IRQ_FULL]     = flag_rise[3];
   assign ev[`DFC_IRQ_EMPTY]    = flag_rise[0];
   assign ev[`DFC_IRQ_BLK_DONE] = busy_q & (state_q == ST_IDLE);
   wire clr_sts = wr_acc & (wb_adr_i == `DFC_REG_IRQ_STS);

   genvar gi;
   generate
      for (gi = 0; gi < `DFC_IRQ_W; gi = gi + 1) begin : g_ists
         always @(posedge core_clk or negedge rstn) begin
            if (!rstn)
               ists_q[gi] <= 1'b0;
            else if (ev[gi])
               ists_q[gi] <= 1'b1;
            else if (clr_sts && wb_dat_i[gi])
               ists_q[gi] <= 1'b0;
         end
      end
   endgenerate

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         irq_o <= 1'b0;
      else
         irq_o <= |(ists_q & imsk_q);
   end

   // Pulses as the device will see them at the next edge
   wire wr_pulse = write_enable_a & write_enable_b;
   wire ld_pulse = read_enable & load_not_shift;

   // Host-side fill estimate, counts own writes minus loads
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         lvl_lo_q <= 13'h0000;
      else if (state_q == ST_RESET)
         lvl_lo_q <= 13'h0000;
      else if (wr_pulse && !ld_pulse)
         lvl_lo_q <= lvl_lo_q + 13'h0001;
      else if (ld_pulse && !wr_pulse && lvl_lo_q != 13'h0000)
         lvl_lo_q <= lvl_lo_q - 13'h0001;
   end

   // Transfer engine
   // all pins driven from one edge
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q             <= ST_IDLE;
         busy_q              <= 1'b0;
         cmd_q               <= `DFC_CMD_NONE;
         count_q             <= {CW{1'b0}};
         tmr_q               <= 8'h00;
         rd_pend_q           <= 1'b0;
         wr_pend_q           <= 1'b0;
         rdata_q             <= {DW{1'b0}};
         write_port_clock_en <= 1'b0;
         read_port_clock_en  <= 1'b0;
         async_reset_n       <= 1'b0;
         write_enable_a      <= 1'b0;
         write_enable_b      <= 1'b0;
         write_data_in       <= {DW{1'b0}};
         read_enable         <= 1'b0;
         load_not_shift      <= 1'b0;
         serial_in           <= 1'b0;
      end else begin
         write_port_clock_en <= 1'b1;
         read_port_clock_en  <= 1'b1;
         serial_in           <= ctrl_q[`DFC_CTRL_SI_LEVEL];
         write_enable_a      <= 1'b0;
         write_enable_b      <= 1'b0;
         read_enable         <= 1'b0;
         rd_pend_q           <= read_enable;
         wr_pend_q           <= write_enable_a;
         // capture output after load or shift
         if (rd_pend_q)
            rdata_q <= read_data_out;
         case (state_q)
            ST_IDLE: begin
               async_reset_n <= 1'b1;
               busy_q        <= 1'b0;
               if (rst_go) begin
                  busy_q        <= 1'b1;
                  async_reset_n <= 1'b0;
                  tmr_q         <= RST_CYC;
                  state_q       <= ST_RESET;
               end else if (blk_go && wb_dat_i[1:0] != `DFC_CMD_NONE) begin
                  busy_q  <= 1'b1;
                  cmd_q   <= wb_dat_i[1:0];
                  count_q <= (wb_dat_i[CW+1:2] == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1}
                                                               : wb_dat_i[CW+1:2];
                  state_q <= (wb_dat_i[1:0] == `DFC_CMD_WRITE) ? ST_WRITE : ST_READ;
               end
            end
            // hold reset low its least width
            ST_RESET: begin
               if (tmr_q <= 8'h01) begin
                  async_reset_n <= 1'b1;
                  state_q       <= ST_IDLE;
               end else
                  tmr_q <= tmr_q - 8'h01;
            end
            // both write enables for a store
            ST_WRITE: begin
               if (pace_ok && f_full && !sync_m)
                  state_q <= ST_WAIT;
               else if (pace_ok && wr_ok) begin
                  write_enable_a <= 1'b1;
                  write_enable_b <= 1'b1;
                  write_data_in  <= wdata_q;
                  tmr_q          <= LAT_CYC;
                  if (count_q == {{(CW-1){1'b0}}, 1'b1})
                     state_q <= ST_WAIT;
                  count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
               end
            end
            ST_READ: begin
               // stop at empty boundary for loads
               if (pace_ok && cmd_q == `DFC_CMD_LOAD && f_empty && !sync_m)
                  state_q <= ST_WAIT;
               else if (pace_ok && (cmd_q == `DFC_CMD_SHIFT || rd_ok)) begin
                  read_enable    <= 1'b1;
                  load_not_shift <= (cmd_q == `DFC_CMD_LOAD);
                  tmr_q          <= LAT_CYC;
                  if (count_q == {{(CW-1){1'b0}}, 1'b1})
                     state_q <= ST_WAIT;
                  count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
               end
            end
            // Let flags and read data settle before the block is reported done
            ST_WAIT: begin
               if (tmr_q <= 8'h01 && pace_ok) begin
                  cmd_q   <= `DFC_CMD_NONE;
                  state_q <= ST_IDLE;
               end else if (tmr_q > 8'h01)
                  tmr_q <= tmr_q - 8'h01;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

endmodule

// file: dv/dfc_host_chk.sv
// Checker of the FIFO host controller bus, pin and reset behaviour
`timescale 1ns/1ps
module dfc_host_chk #(
   parameter DW = 9,
   parameter CW = 16
) (
   // Clock and reset
   input wire          core_clk,
   input wire          rstn,
   // Bus
   input wire          wb_cyc_i,
   input wire          wb_stb_i,
   input wire          wb_we_i,
   input wire [7:0]    wb_adr_i,
   input wire [3:0]    wb_sel_i,
   input wire [31:0]   wb_dat_i,
   input wire [31:0]   wb_dat_o,
   input wire          wb_ack_o,
   input wire          irq_o,
   // Device pins
   input wire          write_port_clock_en,
   input wire          read_port_clock_en,
   input wire          async_reset_n,
   input wire          write_enable_a,
   input wire          write_enable_b,
   input wire [DW-1:0] write_data_in,
   input wire          read_enable,
   input wire          load_not_shift,
   input wire          serial_in,
   input wire [DW-1:0] read_data_out,
   input wire          empty_flag_n,
   input wire          near_boundary_flag_n,
   input wire          half_full_flag_n,
   input wire          full_flag_n
);
   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   wire req     = wb_cyc_i && wb_stb_i;
   wire ctrl_wr = req && wb_we_i && wb_adr_i == 8'h00;

   AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
      else $error("ack without request");
   AST_CLK_EN: assert property (rstn |=> write_port_clock_en && read_port_clock_en)
      else $error("port clocks not enabled");
   AST_RST_PULSE: assert property ($fell(async_reset_n) |=> async_reset_n)
      else $error("device reset pulse not one cycle");
   AST_QUIET_RST: assert property (!async_reset_n |-> !read_enable && !write_enable_a)
      else $error("device access during its reset");
   AST_NO_LOAD_EMPTY: assert property (read_enable && load_not_shift |-> empty_flag_n)
      else $error("load from empty device");
   AST_SI_CAUSE: assert property ($changed(serial_in) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
      else $error("serial input moved without control write");
   AST_WR_PAIR: assert property (write_enable_a == write_enable_b)
      else $error("write enables not paired");
   AST_RD_PACE: assert property (read_enable |=> !read_enable)
      else $error("read pulses back to back");

   COV_WRITE: cover property (write_enable_a && write_enable_b);
   COV_LOAD: cover property (read_enable && load_not_shift);
   COV_SHIFT: cover property (read_enable && !load_not_shift);
   COV_IRQ: cover property (irq_o);
endmodule

bind dfc_host dfc_host_chk #(.DW(DW), .CW(CW)) dfc_host_chk_inst (
   .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .write_port_clock_en(write_port_clock_en), .read_port_clock_en(read_port_clock_en),
   .async_reset_n(async_reset_n), .write_enable_a(write_enable_a),
   .write_enable_b(write_enable_b), .write_data_in(write_data_in),
   .read_enable(read_enable), .load_not_shift(load_not_shift), .serial_in(serial_in),
   .read_data_out(read_data_out), .empty_flag_n(empty_flag_n),
   .near_boundary_flag_n(near_boundary_flag_n), .half_full_flag_n(half_full_flag_n),
   .full_flag_n(full_flag_n));

// file: dv/dfc_fifo_model.sv
// Behavioural model of the 4096 x 9 FIFO device on a common clock
`timescale 1ns/1ps
module dfc_fifo_model (
   // Clock and reset
   input  wire       clk,
   input  wire       wclk_en,
   input  wire       rclk_en,
   input  wire       rst_n,
   // Ports
   input  wire       wen_a,
   input  wire       wen_b,
   input  wire [8:0] din,
   input  wire       ren,
   input  wire       lns,
   input  wire       si,
   output reg  [8:0] q,
   // Flags
   output wire       ef_n,
   output wire       aef_n,
   output wire       hf_n,
   output wire       ff_n
);
   reg  [8:0]  mem [0:4095];
   reg  [11:0] wp_q;
   reg  [11:0] rp_q;
   reg  [12:0] cnt_q;
   wire        wr = wclk_en && wen_a && wen_b;
   wire        ld = rclk_en && ren && lns;
   assign ef_n  = cnt_q != 13'h0;
   assign ff_n  = cnt_q != 13'h1000;
   assign hf_n  = cnt_q <= 13'h800;
   assign aef_n = cnt_q >= 13'h8 && cnt_q <= 13'hff8;
   // one common edge, async reset keeps array
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q  <= 12'h0;
         rp_q  <= 12'h0;
         cnt_q <= 13'h0;
         q     <= 9'h0;
      end else begin
         if (wr) begin
            mem[wp_q] <= din;
            wp_q      <= wp_q + 12'h1;
         end
         if (ld) begin
            q    <= mem[rp_q];
            rp_q <= rp_q + 12'h1;
         end else if (rclk_en && ren) begin
            q <= {si, q[8:1]};
         end
         cnt_q <= cnt_q + {12'h0, wr} - {12'h0, ld};
      end
   end
endmodule

// file: dv/dfc_host_tb.sv
// Self-checking bench of the FIFO host controller against the device model
`timescale 1ns/1ps
module dfc_host_tb;
   typedef struct {logic [7:0] a; logic [31:0] e;} dfc_row_t;
   logic        core_clk, rstn, cyc, we, ack, irq, wcen, rcen, drst_n, wea, web;
   logic        ren, lns, si, ef_n, aef_n, hf_n, ff_n;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, rd;
   logic [8:0]  din, q;
   int          fail_count, cmp_count, i;
   dfc_row_t    rows [5] = '{'{8'h00, 32'h4}, '{8'h04, 32'hc}, '{8'h14, 32'h0},
                             '{8'h1c, 32'h0}, '{8'h20, 32'h0}};

   dfc_host dfc_host_inst (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .irq_o(irq), .write_port_clock_en(wcen), .read_port_clock_en(rcen),
      .async_reset_n(drst_n), .write_enable_a(wea), .write_enable_b(web),
      .write_data_in(din), .read_enable(ren), .load_not_shift(lns), .serial_in(si),
      .read_data_out(q), .empty_flag_n(ef_n), .near_boundary_flag_n(aef_n),
      .half_full_flag_n(hf_n), .full_flag_n(ff_n));
   dfc_fifo_model dfc_fifo_model_inst (.clk(core_clk), .wclk_en(wcen), .rclk_en(rcen),
      .rst_n(drst_n), .wen_a(wea), .wen_b(web), .din(din), .ren(ren), .lns(lns), .si(si),
      .q(q), .ef_n(ef_n), .aef_n(aef_n), .hf_n(hf_n), .ff_n(ff_n));

   function automatic logic [31:0] st(input int n);
      st = {25'h0, n == 0 ? 3'h0 : n < 8 ? 3'h1 : n <= 2048 ? 3'h2 : n <= 4088 ? 3'h3 :
            n < 4096 ? 3'h4 : 3'h5, n != 4096, n <= 2048, n >= 8 && n <= 4088, n != 0};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = rdat;
      cyc <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1, "no ack");
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
      bus(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   // Busy polling bounded; a stuck engine counts as a mismatch
   task automatic idle;
      int n;
      n = 0;
      do begin
         bus(1'b0, 8'h04, 32'h0);
         n++;
      end while (rd[7] !== 1'b0 && n < 6000);
      if (rd[7] !== 1'b0) chk(32'h0, 32'h1, "engine stuck busy");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #(50 * 40000);
      fail_count++;
      end_of_test;
   end
   initial begin
      {rstn, cyc, we, adr, wdat, fail_count, cmp_count} = '0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      for (i = 0; i < 5; i++) rchk(rows[i].a, rows[i].e, "reset value");
      $display("test reset values done");
      bus(1'b1, 8'h10, 32'h1a5);
      bus(1'b1, 8'h18, 32'hd);
      idle;
      rchk(8'h04, st(3), "three words");
      chk({31'h0, irq}, 32'h0, "masked irq");
      bus(1'b1, 8'h0c, 32'h10);
      rchk(8'h0c, 32'h10, "mask");
      chk({31'h0, irq}, 32'h1, "irq raised");
      bus(1'b1, 8'h08, 32'h10);
      rchk(8'h08, 32'h0, "status cleared");
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test write and irq done");
      bus(1'b1, 8'h18, 32'h2);
      idle;
      rchk(8'h14, 32'h1a5, "load");
      rchk(8'h1c, 32'h2, "level");
      bus(1'b1, 8'h00, 32'h6);
      bus(1'b1, 8'h18, 32'h3);
      idle;
      rchk(8'h14, 32'h1d2, "shift");
      $display("test load and shift done");
      bus(1'b1, 8'h18, 32'h12);
      idle;
      rchk(8'h1c, 32'h0, "underrun level");
      rchk(8'h04, st(0), "underrun flags");
      bus(1'b1, 8'h00, 32'h7);
      bus(1'b1, 8'h18, 32'h2);
      repeat (10) @(posedge core_clk);
      rchk(8'h04, st(0) | 32'h80, "load stalls on empty");
      bus(1'b1, 8'h00, 32'h6);
      idle;
      rchk(8'h1c, 32'h0, "no underrun");
      $display("test underrun guard done");
      bus(1'b1, 8'h18, 32'h4001);
      idle;
      rchk(8'h04, st(4096), "full flags");
      bus(1'b1, 8'h00, 32'h7);
      bus(1'b1, 8'h18, 32'h1);
      repeat (10) @(posedge core_clk);
      rchk(8'h04, st(4096) | 32'h80, "write stalls on full");
      bus(1'b1, 8'h00, 32'h6);
      idle;
      rchk(8'h1c, 32'h1000, "overrun guard");
      $display("test full and gate done");
      bus(1'b1, 8'h00, 32'hf);
      idle;
      rchk(8'h04, st(0), "device reset");
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      for (i = 0; i < 5; i++) rchk(rows[i].a, rows[i].e, "second reset");
      $display("test resets done");
      end_of_test;
   end
endmodule
